/* verilog/ptc_pkg.sv */
/*
 Constants for the per-port timestamp correction register group.
 Assumes a plain register port on core_clk and a synchronous active-low reset.
*/
package ptc_pkg;
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_BANK_SEL    = 12'h154;
    localparam logic [11:0] OFS_LATENCY     = 12'h158;
    localparam logic [11:0] OFS_ASYM_PEER   = 12'h15C;
    localparam logic [11:0] OFS_CAP_COUNTS  = 12'h160;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h170;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h174;
    localparam logic [11:0] OFS_CMD_CTL     = 12'h178;
    localparam logic [15:0] EGRESS_LAT_RST  = 16'h005F;
    localparam logic [15:0] INGRESS_LAT_RST = 16'h011D;
    localparam logic [2:0]  BANK_GENERAL    = 3'h0;
    localparam logic [2:0]  BANK_RX         = 3'h1;
    localparam logic [2:0]  BANK_TX         = 3'h2;
    localparam logic [2:0]  BANK_GPIO       = 3'h3;
    localparam int          CNT_W           = 3;
    localparam int          EGR_CNT_LSB     = 4;
    localparam int          ING_CNT_LSB     = 0;
    localparam int          BANK_LSB        = 0;
    localparam int          GPIO_SEL_LSB    = 8;
    localparam int          IRQ_INGRESS     = 0;
    localparam int          IRQ_EGRESS      = 1;
    localparam int          ENABLE_BIT      = 0;
endpackage

/* verilog/ptc_stamp_counter.sv */
/*
 Saturating up/down counter of waiting timestamps.
 Assumes one-cycle increment and decrement pulses on core_clk.
*/
`timescale 1ns/1ps
module ptc_stamp_counter #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Events
    input  wire logic             inc,
    input  wire logic             dec,
    // Count
    output logic [WIDTH-1:0]      count_reg
);
    localparam logic [WIDTH-1:0] MAX = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            count_reg <= '0;
        else if (inc && !dec && count_reg != MAX)
            count_reg <= count_reg + ONE;
        else if (dec && !inc && count_reg != '0)
            count_reg <= count_reg - ONE;
    end
endmodule

/* verilog/ptc_port_regs.sv */
/*
 Per-port timestamp correction registers: latencies, asymmetry, peer delay,
 waiting-timestamp counts, bank select and a small interrupt block.
 Assumes packet events are one-cycle pulses on core_clk from on-chip logic.
*/
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module ptc_port_regs
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // Register port
    input  wire logic [ptc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // Packet events
    input  wire logic                       egress_pkt,
    input  wire logic                       ingress_pkt,
    // Write-one strobes of the timestamp interrupt bits
    input  wire logic                       egress_stamp_irq,
    input  wire logic                       ingress_stamp_irq,
    // Correction values to the timestamp path
    output logic      [15:0]                egress_latency_ns,
    output logic      [15:0]                ingress_latency_ns,
    output logic      [15:0]                path_asymmetry_ns,
    output logic      [15:0]                peer_delay_ns,
    // Bank selection to the shared window, and timestamp enable
    output logic      [2:0]                 bank_sel,
    output logic      [2:0]                 gpio_sel,
    output logic                            timestamp_enable,
    // Interrupt
    output logic                            irq
);
    import ptc_pkg::*;

    logic [15:0]      egr_lat_reg;
    logic [15:0]      ing_lat_reg;
    logic [15:0]      asym_reg;
    logic [15:0]      peer_reg;
    logic [2:0]       bank_reg;
    logic [2:0]       gpio_reg;
    logic             enable_reg;
    logic [1:0]       status_reg;
    logic [1:0]       mask_reg;
    logic [1:0]       status_next;
    logic [CNT_W-1:0] egr_cnt;
    logic [CNT_W-1:0] ing_cnt;
    logic             port_bank;
    logic             wr_lat;
    logic             wr_asym;
    logic [31:0]      rdata_next;

    // Only the port general bank owns the correction words
    assign port_bank = (bank_reg == BANK_GENERAL);
    assign wr_lat    = reg_wr && port_bank && reg_addr == OFS_LATENCY;
    assign wr_asym   = reg_wr && port_bank && reg_addr == OFS_ASYM_PEER;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            egr_lat_reg <= EGRESS_LAT_RST;
            ing_lat_reg <= INGRESS_LAT_RST;
        end
        else if (wr_lat)
        begin
            egr_lat_reg <= reg_wdata[31:16];
            ing_lat_reg <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            asym_reg <= '0;
            peer_reg <= '0;
        end
        else if (wr_asym)
        begin
            asym_reg <= reg_wdata[31:16];
            peer_reg <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            bank_reg <= BANK_GENERAL;
            gpio_reg <= '0;
        end
        else if (reg_wr && reg_addr == OFS_BANK_SEL)
        begin
            bank_reg <= reg_wdata[BANK_LSB +: 3];
            gpio_reg <= reg_wdata[GPIO_SEL_LSB +: 3];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            enable_reg <= 1'b0;
        else if (reg_wr && reg_addr == OFS_CMD_CTL)
            enable_reg <= reg_wdata[ENABLE_BIT];
    end

    // Software writing the strobes is what consumes a stamp
    ptc_stamp_counter #(
        .WIDTH (CNT_W)
    ) u_egr_cnt (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .inc       (egress_pkt),
        .dec       (egress_stamp_irq),
        .count_reg (egr_cnt)
    );

    ptc_stamp_counter #(
        .WIDTH (CNT_W)
    ) u_ing_cnt (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .inc       (ingress_pkt),
        .dec       (ingress_stamp_irq),
        .count_reg (ing_cnt)
    );

    // Sticky events; a new event beats a same-cycle clear
    always_comb
    begin
        status_next = status_reg;
        if (reg_wr && reg_addr == OFS_IRQ_STATUS)
            status_next = status_reg & ~reg_wdata[1:0];
        status_next[IRQ_EGRESS]  = status_next[IRQ_EGRESS] | egress_pkt;
        status_next[IRQ_INGRESS] = status_next[IRQ_INGRESS] | ingress_pkt;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            status_reg <= '0;
        else
            status_reg <= status_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            mask_reg <= '0;
        else if (reg_wr && reg_addr == OFS_IRQ_MASK)
            mask_reg <= reg_wdata[1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(status_next & mask_reg);
    end

    // Read mux; other banks read zero at the latency, asymmetry and capture words, other addresses read zero, capture word ignores writes
    always_comb
    begin
        rdata_next = '0;
        case (reg_addr)
            OFS_BANK_SEL:
                rdata_next = {21'h0, gpio_reg, 5'h0, bank_reg};
            OFS_LATENCY:
                if (port_bank)
                    rdata_next = {egr_lat_reg, ing_lat_reg};
            OFS_ASYM_PEER:
                if (port_bank)
                    rdata_next = {asym_reg, peer_reg};
            OFS_CAP_COUNTS:
                if (port_bank)
                begin
                    rdata_next[EGR_CNT_LSB +: CNT_W] = egr_cnt;
                    rdata_next[ING_CNT_LSB +: CNT_W] = ing_cnt;
                end
            OFS_IRQ_STATUS:
                rdata_next = {30'h0, status_reg};
            OFS_IRQ_MASK:
                rdata_next = {30'h0, mask_reg};
            OFS_CMD_CTL:
                rdata_next = {31'h0, enable_reg};
            default:
                rdata_next = '0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= '0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            egress_latency_ns  <= EGRESS_LAT_RST;
            ingress_latency_ns <= INGRESS_LAT_RST;
            path_asymmetry_ns  <= '0;
            peer_delay_ns      <= '0;
            bank_sel           <= BANK_GENERAL;
            gpio_sel           <= '0;
            timestamp_enable   <= 1'b0;
        end
        else
        begin
            egress_latency_ns  <= egr_lat_reg;
            ingress_latency_ns <= ing_lat_reg;
            path_asymmetry_ns  <= asym_reg;
            peer_delay_ns      <= peer_reg;
            bank_sel           <= bank_reg;
            gpio_sel           <= gpio_reg;
            timestamp_enable   <= enable_reg;
        end
    end
endmodule

/* dv/ptc_regs_sva.sv */
/*
 Port-side assertions for the timestamp correction register group.
 Assumes binding to ptc_port_regs with a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ptc_regs_sva
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic                       core_clk,
    input wire logic                       nrst,
    // Register port
    input wire logic [ptc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0]                reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [31:0]                reg_rdata,
    // Correction values and bank
    input wire logic [15:0]                egress_latency_ns,
    input wire logic [15:0]                ingress_latency_ns,
    input wire logic [15:0]                path_asymmetry_ns,
    input wire logic [15:0]                peer_delay_ns,
    input wire logic [2:0]                 bank_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic win;
    // Outputs lag by one cycle, so no write in the cycle before
    assign win = reg_addr inside {OFS_LATENCY, OFS_ASYM_PEER, OFS_CAP_COUNTS};
    property p_cap_res;
        reg_rd && reg_addr == OFS_CAP_COUNTS |=> reg_rdata[31:7] == 25'h0 && !reg_rdata[3];
    endproperty
    property p_lat_rst;
        $rose(nrst) |-> egress_latency_ns == 16'h005F && ingress_latency_ns == 16'h011D;
    endproperty
    property p_asym_rst;
        $rose(nrst) |-> path_asymmetry_ns == 16'h0 && peer_delay_ns == 16'h0;
    endproperty
    property p_lat_wr;
        reg_wr && reg_addr == OFS_LATENCY && bank_sel == BANK_GENERAL && !$past(reg_wr)
            |-> ##2 {egress_latency_ns, ingress_latency_ns} == $past(reg_wdata, 2);
    endproperty
    property p_asym_wr;
        reg_wr && reg_addr == OFS_ASYM_PEER && bank_sel == BANK_GENERAL && !$past(reg_wr)
            |-> ##2 {path_asymmetry_ns, peer_delay_ns} == $past(reg_wdata, 2);
    endproperty
    property p_bank_wr;
        reg_wr && reg_addr == OFS_BANK_SEL |-> ##2 bank_sel == $past(reg_wdata[2:0], 2);
    endproperty
    property p_bank_rd;
        reg_rd && win && bank_sel != BANK_GENERAL && !$past(reg_wr) |=> reg_rdata == 32'h0;
    endproperty
    property p_bank_ign;
        reg_wr && win && bank_sel != BANK_GENERAL && !$past(reg_wr)
            |-> ##2 $stable(egress_latency_ns) && $stable(path_asymmetry_ns);
    endproperty
    a_cap_res: assert property (p_cap_res)
        else $error("capture count reserved bits set");
    a_lat_rst: assert property (p_lat_rst)
        else $error("latency reset value wrong");
    a_asym_rst: assert property (p_asym_rst)
        else $error("asymmetry or peer delay not zero after reset");
    a_lat_wr: assert property (p_lat_wr)
        else $error("latency outputs do not follow write");
    a_asym_wr: assert property (p_asym_wr)
        else $error("asymmetry or peer delay do not follow write");
    a_bank_wr: assert property (p_bank_wr)
        else $error("bank select does not follow write");
    a_bank_rd: assert property (p_bank_rd)
        else $error("other bank read not zero");
    a_bank_ign: assert property (p_bank_ign)
        else $error("other bank write changed port values");
    c_lat_wr: cover property (p_lat_wr);
    c_bank_rd: cover property (reg_rd && win && bank_sel != BANK_GENERAL);
    c_cap_rd: cover property (reg_rd && reg_addr == OFS_CAP_COUNTS ##1 reg_rdata != 32'h0);
endmodule

/* dv/tb_top.sv */
/*
 Self-checking bench for ptc_port_regs: table of writes and readbacks,
 then counts, interrupt, banks and a second reset. Assumes ptc_pkg.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import ptc_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ptc_row_s;
    logic        core_clk, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, timestamp_enable;
    logic        egress_pkt = 1'b0, ingress_pkt = 1'b0;
    logic        egress_stamp_irq = 1'b0, ingress_stamp_irq = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] egress_latency_ns, ingress_latency_ns, path_asymmetry_ns, peer_delay_ns;
    logic [2:0]  bank_sel, gpio_sel;
    int          n_mismatch = 0, num_checks = 0;
    // Mode latencies, signed asymmetry, then read-only and unmapped places
    ptc_row_s    rows [5] = '{'{OFS_LATENCY, 32'h0473068A, 32'h0473068A},
        '{OFS_LATENCY, 32'h004400E7, 32'h004400E7}, '{OFS_ASYM_PEER, 32'hFFF60064, 32'hFFF60064},
        '{OFS_CAP_COUNTS, 32'hFFFFFFFF, 32'h0}, '{12'h300, 32'hFFFFFFFF, 32'h0}};
    ptc_port_regs ptc_port_regs_i (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .egress_pkt, .ingress_pkt, .egress_stamp_irq, .ingress_stamp_irq,
        .egress_latency_ns, .ingress_latency_ns, .path_asymmetry_ns, .peer_delay_ns,
        .bank_sel, .gpio_sel, .timestamp_enable, .irq);
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK($sformatf("read %h", a), e, reg_rdata)
    endtask
    // Order: egress packet, ingress packet, egress clear, ingress clear
    task automatic pulse(input logic [3:0] p);
        @(posedge core_clk);
        {egress_pkt, ingress_pkt, egress_stamp_irq, ingress_stamp_irq} <= p;
        @(posedge core_clk);
        {egress_pkt, ingress_pkt, egress_stamp_irq, ingress_stamp_irq} <= 4'h0;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFS_LATENCY, 32'h005F011D);
        rd(OFS_ASYM_PEER, 32'h0);
        rd(OFS_CAP_COUNTS, 32'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        `CHK("egress lat", 16'h0044, egress_latency_ns)
        `CHK("ingress lat", 16'h00E7, ingress_latency_ns)
        `CHK("asym", 16'hFFF6, path_asymmetry_ns)
        `CHK("peer", 16'h0064, peer_delay_ns)
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_IRQ_STATUS, 32'h3);
        repeat (9) pulse(4'b1000);
        repeat (2) pulse(4'b0100);
        rd(OFS_CAP_COUNTS, 32'h72);
        `CHK("irq", 1'b1, irq)
        pulse(4'b0101);
        rd(OFS_CAP_COUNTS, 32'h72);
        repeat (8) pulse(4'b0010);
        rd(OFS_CAP_COUNTS, 32'h02);
        pulse(4'b0001);
        rd(OFS_CAP_COUNTS, 32'h01);
        wr(OFS_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("irq", 1'b0, irq)
        rd(OFS_IRQ_STATUS, 32'h1);
        // Event and clear in one cycle: the event must win
        @(posedge core_clk);
        reg_addr <= OFS_IRQ_STATUS;
        reg_wdata <= 32'h1;
        reg_wr <= 1'b1;
        ingress_pkt <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        ingress_pkt <= 1'b0;
        rd(OFS_IRQ_STATUS, 32'h1);
        rd(OFS_CAP_COUNTS, 32'h02);
        wr(OFS_IRQ_MASK, 32'h1);
        rd(OFS_IRQ_MASK, 32'h1);
        `CHK("irq", 1'b1, irq)
        // Timestamping is switched off again before the other-bank correction writes
        wr(OFS_CMD_CTL, 32'h1);
        rd(OFS_CMD_CTL, 32'h1);
        `CHK("enable", 1'b1, timestamp_enable)
        wr(OFS_CMD_CTL, 32'h0);
        rd(OFS_CMD_CTL, 32'h0);
        `CHK("enable", 1'b0, timestamp_enable)
        for (int b = 1; b < 8; b++)
        begin
            wr(OFS_BANK_SEL, 32'h500 | 32'(b));
            wr(OFS_LATENCY, 32'h12345678);
            rd(OFS_LATENCY, 32'h0);
        end
        rd(OFS_BANK_SEL, 32'h507);
        `CHK("bank sel", 3'h7, bank_sel)
        `CHK("gpio sel", 3'h5, gpio_sel)
        wr(OFS_BANK_SEL, 32'h0);
        rd(OFS_LATENCY, 32'h004400E7);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFS_LATENCY, 32'h005F011D);
        rd(OFS_CAP_COUNTS, 32'h0);
        close_out;
    end
    // Whole run is under two hundred cycles
    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        close_out;
    end
endmodule
bind ptc_port_regs ptc_regs_sva ptc_regs_sva_i (.core_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .egress_latency_ns, .ingress_latency_ns,
    .path_asymmetry_ns, .peer_delay_ns, .bank_sel);
